// ===== logic/ep0_pkg.sv
// constants and types shared by both ends of the endpoint-zero link
package ep0_pkg;
   localparam int EP0_MAX_PKT = 64;
   localparam int SETUP_LEN = 8;
   localparam int HOST_TIMEOUT = 64;
   localparam logic [7:0] INDEX_ADDR = 8'h0e;
   localparam logic [7:0] CSR_ADDR = 8'h11;
   localparam logic [7:0] COUNT_ADDR = 8'h16;
   localparam logic [7:0] FIFO_ADDR = 8'h20;
   localparam logic [7:0] CSR_RESET = 8'h00;
   localparam logic [3:0] INDEX_RESET = 4'h0;
   localparam int CSR_OPR = 0;
   localparam int CSR_INPR = 1;
   localparam int CSR_STALLED = 2;
   localparam int CSR_MARK = 3;
   localparam int CSR_SETUP_END_FLAG = 4;
   localparam int CSR_FORCE = 5;
   localparam int CSR_SERVICED = 6;
   localparam int CSR_SETUP_END_FLAG_ACK = 7;
   typedef enum logic [1:0] {PID_SETUP = 2'b00, PID_OUT = 2'b01, PID_IN = 2'b10} pid_e;
   typedef enum logic [1:0] {HS_ACK = 2'b00, HS_NAK = 2'b01, HS_STALL = 2'b10,
      HS_NONE = 2'b11} hs_e;
endpackage

// ===== logic/ep0_link_if.sv
// token, data and handshake link between usb host and endpoint zero
`timescale 1ns/10ps
interface ep0_link_if
(
   input wire logic clock,
   input wire logic rst_b
);
   import ep0_pkg::*;
   logic tok_valid;
   pid_e tok_pid;
   logic dat_valid;
   logic [7:0] dat_byte;
   logic dat_last;
   logic dat_empty;
   logic dat_data1;
   logic dat_err;
   logic ack_valid;
   logic hs_valid;
   hs_e hs_code;
   logic tx_valid;
   logic [7:0] tx_byte;
   logic tx_last;
   logic tx_empty;
   modport device (input clock, rst_b, tok_valid, tok_pid, dat_valid, dat_byte, dat_last,
      dat_empty, dat_data1, dat_err, ack_valid,
      output hs_valid, hs_code, tx_valid, tx_byte, tx_last, tx_empty);
   modport host (input clock, rst_b, hs_valid, hs_code, tx_valid, tx_byte, tx_last, tx_empty,
      output tok_valid, tok_pid, dat_valid, dat_byte, dat_last, dat_empty, dat_data1,
      dat_err, ack_valid);
endinterface

// ===== logic/ep0_device_end.sv
// endpoint-zero control handler with its control/status register and packet buffer
// Operation
// - received setup/out sets out-ready, raises event
// - event on in transfer status stage
// - early transfer end sets setup-end, raises event
// - byte count shows bytes held
// - stall repeated token after last-packet mark
// - stall packets longer than maximum size
// - stall nonzero data1 in in-status stage
// - stall sets sticky sent flag, raises event
// - reject setup not exactly eight bytes
// - serviced-out write clears out-ready; reads zero
// - in without in-ready gets nak, no event
// - first in enters transmit; setup/out ends badly
// - transmit ends on setup/out or short packet
// - first out enters receive; setup/in ends badly
// - receive ends on setup/in or short packet
// - force-stall cleared after stall sent
// - setup-end ack clears flag; reads zero
// - last-packet mark set with ready, auto-cleared
// - in-ready cleared with event on send/overwrite
// - firmware splits in data, ends multiples with zlp
// - host ends out multiples with zlp
// - firmware selects index zero first
// - corrupted packets silently discarded
`timescale 1ns/10ps
module ep0_device_end #(parameter int MAX_PKT = ep0_pkg::EP0_MAX_PKT)
(
   ep0_link_if.device link,
   input wire logic fw_wr,
   input wire logic fw_rd,
   input wire logic [7:0] fw_addr,
   input wire logic [7:0] fw_wdata,
   output logic [7:0] fw_rdata,
   output logic ep0_event
);
   import ep0_pkg::*;
   localparam int AW = $clog2(MAX_PKT);
   localparam logic [7:0] MAXP = 8'(MAX_PKT);
   localparam logic [7:0] SETUPP = 8'(SETUP_LEN);
   typedef enum logic [1:0] {ST_IDLE = 2'b00, ST_RX = 2'b01, ST_TX = 2'b10,
      ST_ACK = 2'b11} state_e;
   typedef enum logic [1:0] {MODE_IDLE = 2'b00, MODE_TX = 2'b01, MODE_RX = 2'b10} mode_e;
   logic [7:0] mem [MAX_PKT];
   logic [AW-1:0] wr_ptr, rd_ptr;
   logic [7:0] cnt;
   logic [3:0] ep_index;
   logic opr, inpr, stalled, mark, setup_end_flag, force_stall;
   state_e state, next_state;
   mode_e mode, next_mode;
   logic in_status, next_in_status, out_status, next_out_status;
   logic is_setup, next_is_setup, keep, next_keep, over, next_over, bad, next_bad;
   hs_e resp, next_resp;
   logic [7:0] rx_len, next_rx_len, tx_left, next_tx_left, tx_len, next_tx_len;
   logic tx_status, next_tx_status;
   logic next_hs_valid, next_tx_valid, next_tx_last, next_tx_empty;
   hs_e next_hs_code;
   logic [7:0] next_tx_byte, len_final;
   logic set_opr, clr_inpr, set_setup_end_flag, sent_stall, clr_mark, rx_wr, tx_rd, buf_clr, ev;
   logic csr_wr, fw_out_end, fifo_wr, fifo_rd;

   assign csr_wr = fw_wr && fw_addr == CSR_ADDR && ep_index == 4'h0;
   assign fw_out_end = csr_wr && fw_wdata[CSR_SERVICED] && fw_wdata[CSR_MARK] && mode != MODE_TX;
   assign fifo_wr = fw_wr && fw_addr == FIFO_ADDR && cnt < MAXP;
   assign fifo_rd = fw_rd && fw_addr == FIFO_ADDR && cnt != 8'h00;

   always_comb
   begin
      next_state = state;
      next_mode = mode;
      next_in_status = in_status;
      next_out_status = out_status | fw_out_end;
      next_is_setup = is_setup;
      next_keep = keep;
      next_resp = resp;
      next_over = over;
      next_bad = bad;
      next_rx_len = rx_len;
      next_tx_left = tx_left;
      next_tx_len = tx_len;
      next_tx_status = tx_status;
      next_hs_valid = 1'b0;
      next_hs_code = link.hs_code;
      next_tx_valid = 1'b0;
      next_tx_byte = link.tx_byte;
      next_tx_last = 1'b0;
      next_tx_empty = 1'b0;
      set_opr = 1'b0;
      clr_inpr = 1'b0;
      set_setup_end_flag = 1'b0;
      sent_stall = 1'b0;
      clr_mark = 1'b0;
      rx_wr = 1'b0;
      tx_rd = 1'b0;
      buf_clr = 1'b0;
      ev = 1'b0;
      len_final = link.dat_empty ? rx_len : 8'(rx_len + 8'h01);
      case (state)
         ST_IDLE:
            if (link.tok_valid)
            begin
               next_rx_len = 8'h00;
               next_over = 1'b0;
               next_bad = 1'b0;
               next_is_setup = link.tok_pid == PID_SETUP;
               next_keep = 1'b0;
               next_resp = HS_ACK;
               case (link.tok_pid)
                  PID_SETUP:
                  begin
                     set_setup_end_flag = mode != MODE_IDLE;
                     next_mode = MODE_IDLE;
                     next_in_status = 1'b0;
                     next_out_status = 1'b0;
                     next_keep = 1'b1;
                     next_state = ST_RX;
                  end
                  PID_OUT:
                  begin
                     if (mode == MODE_TX)
                     begin
                        set_setup_end_flag = 1'b1;
                        next_mode = MODE_IDLE;
                     end
                     if (out_status || force_stall)
                        next_resp = HS_STALL;
                     else if (!in_status && opr)
                        next_resp = HS_NAK;
                     else if (!in_status)
                        next_keep = 1'b1;
                     next_state = ST_RX;
                  end
                  PID_IN:
                  begin
                     if (mode == MODE_RX)
                     begin
                        set_setup_end_flag = 1'b1;
                        next_mode = MODE_IDLE;
                     end
                     if (in_status || force_stall)
                     begin
                        next_hs_valid = 1'b1;
                        next_hs_code = HS_STALL;
                        sent_stall = 1'b1;
                     end
                     else if (out_status)
                     begin
                        next_tx_left = 8'h00;
                        next_tx_status = 1'b1;
                        next_state = ST_TX;
                     end
                     else if (!inpr)
                     begin
                        next_hs_valid = 1'b1;
                        next_hs_code = HS_NAK;
                     end
                     else
                     begin
                        next_tx_left = cnt;
                        next_tx_len = cnt;
                        next_tx_status = 1'b0;
                        next_mode = MODE_TX;
                        next_state = ST_TX;
                     end
                  end
                  default:
                     next_state = ST_IDLE;
               endcase
               if (next_keep)
               begin
                  buf_clr = 1'b1;
                  clr_inpr = inpr;
                  ev = inpr;
               end
            end
         ST_RX:
            if (link.dat_valid)
            begin
               if (!link.dat_empty)
               begin
                  next_rx_len = len_final;
                  next_over = over || rx_len >= MAXP;
                  rx_wr = keep && rx_len < MAXP;
               end
               next_bad = bad || link.dat_err;
               if (link.dat_last)
               begin
                  next_state = ST_IDLE;
                  next_hs_valid = 1'b1;
                  next_hs_code = HS_ACK;
                  if (next_bad || (is_setup && len_final != SETUPP))
                  begin
                     next_hs_valid = 1'b0;
                     buf_clr = keep;
                  end
                  else if (next_over || resp == HS_STALL ||
                     (in_status && link.dat_data1 && len_final != 8'h00))
                     sent_stall = 1'b1;
                  else if (in_status)
                  begin
                     ev = 1'b1;
                     next_in_status = 1'b0;
                     clr_mark = 1'b1;
                  end
                  else if (resp == HS_NAK)
                     next_hs_code = HS_NAK;
                  else
                  begin
                     set_opr = 1'b1;
                     ev = 1'b1;
                     if (!is_setup)
                        next_mode = len_final < MAXP ? MODE_IDLE : MODE_RX;
                  end
                  if (sent_stall)
                     next_hs_code = HS_STALL;
               end
            end
         ST_TX:
         begin
            next_tx_valid = 1'b1;
            next_tx_empty = tx_left == 8'h00;
            next_tx_last = tx_left <= 8'h01;
            next_tx_byte = mem[rd_ptr];
            tx_rd = tx_left != 8'h00;
            next_tx_left = tx_rd ? 8'(tx_left - 8'h01) : tx_left;
            if (next_tx_last)
               next_state = ST_ACK;
         end
         ST_ACK:
            if (link.ack_valid)
            begin
               next_state = ST_IDLE;
               ev = 1'b1;
               if (tx_status)
               begin
                  next_out_status = 1'b0;
                  clr_mark = 1'b1;
               end
               else
               begin
                  clr_inpr = 1'b1;
                  if (mark)
                  begin
                     next_in_status = 1'b1;
                     next_mode = MODE_IDLE;
                  end
                  else if (tx_len < MAXP)
                     next_mode = MODE_IDLE;
               end
            end
            else if (link.tok_valid)
               next_state = ST_IDLE;
         default:
            next_state = ST_IDLE;
      endcase
      if (sent_stall)
      begin
         ev = 1'b1;
         next_mode = MODE_IDLE;
         next_in_status = 1'b0;
         next_out_status = 1'b0;
         clr_mark = 1'b1;
      end
   end

   always_ff @(posedge link.clock or negedge link.rst_b)
   begin
      if (!link.rst_b)
      begin
         state <= ST_IDLE;
         mode <= MODE_IDLE;
         in_status <= 1'b0;
         out_status <= 1'b0;
         is_setup <= 1'b0;
         keep <= 1'b0;
         resp <= HS_ACK;
         over <= 1'b0;
         bad <= 1'b0;
         rx_len <= 8'h00;
         tx_left <= 8'h00;
         tx_len <= 8'h00;
         tx_status <= 1'b0;
         link.hs_valid <= 1'b0;
         link.hs_code <= HS_NONE;
         link.tx_valid <= 1'b0;
         link.tx_byte <= 8'h00;
         link.tx_last <= 1'b0;
         link.tx_empty <= 1'b0;
         ep0_event <= 1'b0;
      end
      else
      begin
         state <= next_state;
         mode <= next_mode;
         in_status <= next_in_status;
         out_status <= next_out_status;
         is_setup <= next_is_setup;
         keep <= next_keep;
         resp <= next_resp;
         over <= next_over;
         bad <= next_bad;
         rx_len <= next_rx_len;
         tx_left <= next_tx_left;
         tx_len <= next_tx_len;
         tx_status <= next_tx_status;
         link.hs_valid <= next_hs_valid;
         link.hs_code <= next_hs_code;
         link.tx_valid <= next_tx_valid;
         link.tx_byte <= next_tx_byte;
         link.tx_last <= next_tx_last;
         link.tx_empty <= next_tx_empty;
         ep0_event <= ev | set_setup_end_flag;
      end
   end

   // status flags: hardware set wins over a same-cycle software clear
   always_ff @(posedge link.clock or negedge link.rst_b)
   begin
      if (!link.rst_b)
      begin
         opr <= CSR_RESET[CSR_OPR];
         inpr <= CSR_RESET[CSR_INPR];
         stalled <= CSR_RESET[CSR_STALLED];
         mark <= CSR_RESET[CSR_MARK];
         setup_end_flag <= CSR_RESET[CSR_SETUP_END_FLAG];
         force_stall <= CSR_RESET[CSR_FORCE];
      end
      else
      begin
         opr <= set_opr | (opr & ~(csr_wr & fw_wdata[CSR_SERVICED]));
         inpr <= (csr_wr & fw_wdata[CSR_INPR]) | (inpr & ~clr_inpr);
         stalled <= sent_stall | (stalled & ~(csr_wr & ~fw_wdata[CSR_STALLED]));
         mark <= (csr_wr & fw_wdata[CSR_MARK]) | (mark & ~clr_mark);
         setup_end_flag <= set_setup_end_flag | (setup_end_flag & ~(csr_wr & fw_wdata[CSR_SETUP_END_FLAG_ACK]));
         if (csr_wr)
            force_stall <= fw_wdata[CSR_FORCE];
         else if (sent_stall)
            force_stall <= 1'b0;
      end
   end

   // packet buffer shared by receive, transmit and firmware access
   always_ff @(posedge link.clock)
   begin
      if (rx_wr)
         mem[wr_ptr] <= link.dat_byte;
      else if (fifo_wr)
         mem[wr_ptr] <= fw_wdata;
   end

   always_ff @(posedge link.clock or negedge link.rst_b)
   begin
      if (!link.rst_b)
      begin
         wr_ptr <= '0;
         rd_ptr <= '0;
         cnt <= 8'h00;
      end
      else if (buf_clr)
      begin
         wr_ptr <= '0;
         rd_ptr <= '0;
         cnt <= 8'h00;
      end
      else
      begin
         if (rx_wr || fifo_wr)
            wr_ptr <= wr_ptr + 1'b1;
         if (tx_rd || fifo_rd)
            rd_ptr <= rd_ptr + 1'b1;
         cnt <= 8'(cnt + {7'h00, rx_wr | fifo_wr} - {7'h00, tx_rd | fifo_rd});
      end
   end

   always_ff @(posedge link.clock or negedge link.rst_b)
   begin
      if (!link.rst_b)
      begin
         ep_index <= INDEX_RESET;
         fw_rdata <= 8'h00;
      end
      else
      begin
         if (fw_wr && fw_addr == INDEX_ADDR)
            ep_index <= fw_wdata[3:0];
         if (fw_rd)
         begin
            case (fw_addr)
               INDEX_ADDR:
                  fw_rdata <= {4'h0, ep_index};
               CSR_ADDR:
                  fw_rdata <= ep_index != 4'h0 ? 8'h00 :
                     {2'b00, force_stall, setup_end_flag, mark, stalled, inpr, opr};
               COUNT_ADDR:
                  fw_rdata <= cnt;
               FIFO_ADDR:
                  fw_rdata <= fifo_rd ? mem[rd_ptr] : 8'h00;
               default:
                  fw_rdata <= 8'h00;
            endcase
         end
      end
   end
endmodule

// ===== logic/ep0_host_end.sv
// usb host end issuing endpoint-zero tokens, data packets and acknowledges
`timescale 1ns/10ps
module ep0_host_end #(parameter int MAX_PKT = ep0_pkg::EP0_MAX_PKT,
   parameter int TIMEOUT = ep0_pkg::HOST_TIMEOUT)
(
   ep0_link_if.host link,
   input wire logic load_valid,
   input wire logic [7:0] load_byte,
   input wire logic cmd_valid,
   input wire ep0_pkg::pid_e cmd_pid,
   input wire logic cmd_data1,
   input wire logic cmd_corrupt,
   output logic busy,
   output logic done,
   output ep0_pkg::hs_e result,
   output logic rx_valid,
   output logic [7:0] rx_byte,
   output logic rx_last
);
   import ep0_pkg::*;
   localparam int AW = $clog2(MAX_PKT);
   typedef enum logic [1:0] {H_IDLE = 2'b00, H_TOK = 2'b01, H_DATA = 2'b10,
      H_WAIT = 2'b11} hstate_e;
   logic [7:0] mem [MAX_PKT];
   logic [7:0] len, idx;
   logic [7:0] timer;
   hstate_e state;
   pid_e pid;
   logic data1, corrupt;

   always_ff @(posedge link.clock)
   begin
      if (load_valid && state == H_IDLE)
         mem[len[AW-1:0]] <= load_byte;
   end

   always_ff @(posedge link.clock or negedge link.rst_b)
   begin
      if (!link.rst_b)
      begin
         state <= H_IDLE;
         pid <= PID_SETUP;
         data1 <= 1'b0;
         corrupt <= 1'b0;
         len <= 8'h00;
         idx <= 8'h00;
         timer <= 8'h00;
         busy <= 1'b0;
         done <= 1'b0;
         result <= HS_NONE;
         rx_valid <= 1'b0;
         rx_byte <= 8'h00;
         rx_last <= 1'b0;
         link.tok_valid <= 1'b0;
         link.tok_pid <= PID_SETUP;
         link.dat_valid <= 1'b0;
         link.dat_byte <= 8'h00;
         link.dat_last <= 1'b0;
         link.dat_empty <= 1'b0;
         link.dat_data1 <= 1'b0;
         link.dat_err <= 1'b0;
         link.ack_valid <= 1'b0;
      end
      else
      begin
         done <= 1'b0;
         rx_valid <= 1'b0;
         rx_last <= 1'b0;
         link.tok_valid <= 1'b0;
         link.dat_valid <= 1'b0;
         link.dat_last <= 1'b0;
         link.dat_empty <= 1'b0;
         link.dat_err <= 1'b0;
         link.ack_valid <= 1'b0;
         case (state)
            H_IDLE:
               if (cmd_valid)
               begin
                  pid <= cmd_pid;
                  data1 <= cmd_data1;
                  corrupt <= cmd_corrupt;
                  idx <= 8'h00;
                  busy <= 1'b1;
                  state <= H_TOK;
               end
               else if (load_valid && len < 8'(MAX_PKT + 1))
                  len <= 8'(len + 8'h01);
            H_TOK:
            begin
               link.tok_valid <= 1'b1;
               link.tok_pid <= pid;
               timer <= 8'h00;
               state <= pid == PID_IN ? H_WAIT : H_DATA;
            end
            H_DATA:
            begin
               link.dat_valid <= 1'b1;
               link.dat_data1 <= data1;
               link.dat_byte <= mem[idx[AW-1:0]];
               link.dat_empty <= len == 8'h00;
               link.dat_last <= 8'(idx + 8'h01) >= len;
               link.dat_err <= corrupt && 8'(idx + 8'h01) >= len;
               idx <= 8'(idx + 8'h01);
               if (8'(idx + 8'h01) >= len)
                  state <= H_WAIT;
            end
            H_WAIT:
            begin
               timer <= 8'(timer + 8'h01);
               if (link.hs_valid || (link.tx_valid && link.tx_last) ||
                  timer == 8'(TIMEOUT - 1))
               begin
                  state <= H_IDLE;
                  busy <= 1'b0;
                  done <= 1'b1;
                  len <= 8'h00;
                  result <= link.hs_valid ? link.hs_code :
                     (link.tx_valid ? HS_ACK : HS_NONE);
                  link.ack_valid <= link.tx_valid && !link.hs_valid;
               end
               if (link.tx_valid && !link.tx_empty)
               begin
                  rx_valid <= 1'b1;
                  rx_byte <= link.tx_byte;
                  rx_last <= link.tx_last;
               end
            end
            default:
               state <= H_IDLE;
         endcase
      end
   end
endmodule

// ===== bench/ep0_link_monitor.sv
// link checker for the endpoint-zero host and device ends
`timescale 1ns/10ps
module ep0_link_monitor #(parameter int MAX_PKT = 64)
(
   input wire logic clock,
   input wire logic rst_b,
   input wire logic tok_valid,
   input wire ep0_pkg::pid_e tok_pid,
   input wire logic dat_valid,
   input wire logic dat_last,
   input wire logic dat_empty,
   input wire logic dat_err,
   input wire logic ack_valid,
   input wire logic hs_valid,
   input wire ep0_pkg::hs_e hs_code,
   input wire logic tx_valid,
   input wire logic tx_last,
   input wire logic tx_empty
);
   import ep0_pkg::*;
   int rx_n;
   logic in_setup;
   int beats;
   default clocking @(posedge clock); endclocking
   default disable iff (!rst_b);
   assign beats = rx_n + (dat_empty ? 0 : 1);
   // data beats of the packet so far, zero-length beats excluded
   always_ff @(posedge clock or negedge rst_b)
   begin
      if (!rst_b)
         rx_n <= 0;
      else if (tok_valid)
         rx_n <= 0;
      else if (dat_valid && !dat_empty)
         rx_n <= rx_n + 1;
   end
   always_ff @(posedge clock or negedge rst_b)
   begin
      if (!rst_b)
         in_setup <= 1'b0;
      else if (tok_valid)
         in_setup <= (tok_pid == PID_SETUP);
   end
   out_answered_a: assert property (dat_valid && dat_last && !dat_err && !in_setup |=> hs_valid)
      else $error("no handshake after out data");
   oversize_refused_a: assert property (dat_valid && dat_last && !in_setup && beats > MAX_PKT
      |=> !hs_valid || hs_code != HS_ACK) else $error("oversize packet acked");
   short_setup_a: assert property (in_setup && dat_valid && dat_last && beats != SETUP_LEN
      |=> !hs_valid) else $error("bad setup length answered");
   corrupt_quiet_a: assert property (dat_valid && dat_last && dat_err |=> !hs_valid)
      else $error("corrupt packet answered");
   in_answer_a: assert property (tok_valid && tok_pid == PID_IN |-> (##1 hs_valid) or (##2 tx_valid))
      else $error("in token unanswered");
   tx_burst_a: assert property (tx_valid && !tx_last |=> tx_valid)
      else $error("gap in in data");
   zlp_single_a: assert property (tx_valid && tx_empty |-> tx_last)
      else $error("zero-length beat not last");
   ack_after_tx_a: assert property (ack_valid |-> $past(tx_valid) && $past(tx_last))
      else $error("host ack without in data");
   hs_pulse_a: assert property (hs_valid |=> !hs_valid)
      else $error("handshake longer than one cycle");
   cover property (hs_valid && hs_code == HS_STALL);
   cover property (hs_valid && hs_code == HS_NAK);
   cover property (dat_valid && dat_last && !in_setup && beats > MAX_PKT);
   cover property (ack_valid);
   cover property (tx_valid && tx_empty);
endmodule

// ===== bench/usb_endpoint0_control_tb_top.sv
// bench joining host and device ends of endpoint zero
`timescale 1ns/10ps
module usb_endpoint0_control_tb_top;
   import ep0_pkg::*;
   localparam int MP = 8;
   logic clock = 0;
   logic rst_b = 0;
   logic fw_wr = 0;
   logic fw_rd = 0;
   logic [7:0] fw_addr = 8'h00;
   logic [7:0] fw_wdata = 8'h00;
   logic [7:0] fw_rdata;
   logic ep0_event;
   logic load_valid = 0;
   logic [7:0] load_byte = 8'h00;
   logic cmd_valid = 0;
   pid_e cmd_pid = PID_SETUP;
   logic cmd_data1 = 0;
   logic cmd_corrupt = 0;
   logic busy, done, rx_valid, rx_last;
   hs_e result;
   logic [7:0] rx_byte;
   int bad_count = 0;
   int n_checks = 0;
   int ev_n = 0;
   int rx_n = 0;
   logic [7:0] rx_seen = 8'h00;
   int cyc = 0;
   int e;
   ep0_link_if ep0_link_if_inst (.clock(clock), .rst_b(rst_b));
   ep0_device_end #(.MAX_PKT(MP)) ep0_device_end_inst (.link(ep0_link_if_inst.device),
      .fw_wr(fw_wr), .fw_rd(fw_rd), .fw_addr(fw_addr), .fw_wdata(fw_wdata),
      .fw_rdata(fw_rdata), .ep0_event(ep0_event));
   ep0_host_end #(.MAX_PKT(MP), .TIMEOUT(16)) ep0_host_end_inst (.link(ep0_link_if_inst.host),
      .load_valid(load_valid), .load_byte(load_byte), .cmd_valid(cmd_valid),
      .cmd_pid(cmd_pid), .cmd_data1(cmd_data1), .cmd_corrupt(cmd_corrupt), .busy(busy),
      .done(done), .result(result), .rx_valid(rx_valid), .rx_byte(rx_byte), .rx_last(rx_last));
   ep0_link_monitor #(.MAX_PKT(MP)) ep0_link_monitor_inst (.clock(clock), .rst_b(rst_b),
      .tok_valid(ep0_link_if_inst.tok_valid), .tok_pid(ep0_link_if_inst.tok_pid),
      .dat_valid(ep0_link_if_inst.dat_valid), .dat_last(ep0_link_if_inst.dat_last),
      .dat_empty(ep0_link_if_inst.dat_empty), .dat_err(ep0_link_if_inst.dat_err),
      .ack_valid(ep0_link_if_inst.ack_valid), .hs_valid(ep0_link_if_inst.hs_valid),
      .hs_code(ep0_link_if_inst.hs_code), .tx_valid(ep0_link_if_inst.tx_valid),
      .tx_last(ep0_link_if_inst.tx_last), .tx_empty(ep0_link_if_inst.tx_empty));
   initial
   begin
      forever #5 clock = ~clock;
   end
   task automatic close_out;
      if (bad_count == 0 && n_checks > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask
   always @(posedge clock)
   begin
      cyc++;
      if (ep0_event === 1'b1)
         ev_n++;
      if (rx_valid === 1'b1)
         rx_n++;
      if (rx_last === 1'b1)
         rx_seen = rx_byte;
      if (cyc == 20000)
      begin
         bad_count++;
         close_out();
      end
   end
   task automatic chk(input string what, input logic [7:0] got, input logic [7:0] exp);
      n_checks++;
      if (got !== exp)
      begin
         bad_count++;
         $display("BAD %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic tick;
      @(posedge clock);
      #1;
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      fw_addr = a;
      fw_wdata = d;
      fw_wr = 1;
      tick();
      fw_wr = 0;
      tick();
   endtask
   task automatic rd(input logic [7:0] a, input logic [7:0] x, input string what);
      fw_addr = a;
      fw_rd = 1;
      tick();
      fw_rd = 0;
      tick();
      chk(what, fw_rdata, x);
   endtask
   task automatic xfer(input pid_e p, input int n, input logic d1, input logic bad,
      input hs_e x, input logic look);
      int w;
      for (int k = 0; k < n; k++)
      begin
         load_byte = 8'(k + 1);
         load_valid = 1;
         tick();
      end
      load_valid = 0;
      cmd_pid = p;
      cmd_data1 = d1;
      cmd_corrupt = bad;
      cmd_valid = 1;
      tick();
      cmd_valid = 0;
      w = 0;
      while (done !== 1'b1 && w < 300)
      begin
         tick();
         w++;
      end
      if (w == 300)
         bad_count++;
      if (look)
         chk("result", {6'h00, result}, {6'h00, x});
      // device takes the ack one cycle late, its event one more
      repeat (2) tick();
   endtask
   initial
   begin
      repeat (12) @(posedge clock);
      #1;
      rst_b = 1;
      tick();
      wr(INDEX_ADDR, 8'h00);
      rd(CSR_ADDR, CSR_RESET, "csr reset");
      rd(8'h7f, 8'h00, "unmapped");
      xfer(PID_SETUP, 7, 0, 0, HS_NONE, 1);
      chk("events", 8'(ev_n), 8'h00);
      xfer(PID_SETUP, 8, 0, 0, HS_ACK, 1);
      chk("events", 8'(ev_n), 8'h01);
      rd(CSR_ADDR, 8'h01, "out ready");
      rd(COUNT_ADDR, 8'h08, "count");
      rd(FIFO_ADDR, 8'h01, "fifo byte");
      rd(COUNT_ADDR, 8'h07, "count");
      for (int k = 2; k <= 8; k++)
         rd(FIFO_ADDR, 8'(k), "fifo byte");
      wr(CSR_ADDR, 8'h40);
      rd(CSR_ADDR, 8'h00, "serviced");
      xfer(PID_IN, 0, 0, 0, HS_NAK, 1);
      chk("events", 8'(ev_n), 8'h01);
      wr(FIFO_ADDR, 8'ha5);
      wr(FIFO_ADDR, 8'h5a);
      wr(CSR_ADDR, 8'h0a);
      xfer(PID_IN, 0, 0, 0, HS_ACK, 0);
      chk("in bytes", 8'(rx_n), 8'h02);
      chk("last in byte", rx_seen, 8'h5a);
      chk("events", 8'(ev_n), 8'h02);
      rd(CSR_ADDR, 8'h08, "in done");
      xfer(PID_OUT, 0, 1, 0, HS_ACK, 1);
      chk("events", 8'(ev_n), 8'h03);
      rd(CSR_ADDR, 8'h00, "status done");
      wr(CSR_ADDR, 8'h20);
      xfer(PID_IN, 0, 0, 0, HS_STALL, 1);
      rd(CSR_ADDR, 8'h04, "stall sent");
      wr(CSR_ADDR, 8'h00);
      wr(FIFO_ADDR, 8'h11);
      wr(CSR_ADDR, 8'h0a);
      xfer(PID_IN, 0, 0, 0, HS_ACK, 0);
      chk("last in byte", rx_seen, 8'h11);
      xfer(PID_OUT, 1, 1, 0, HS_STALL, 1);
      wr(CSR_ADDR, 8'h00);
      xfer(PID_SETUP, 8, 0, 0, HS_ACK, 1);
      wr(CSR_ADDR, 8'h40);
      xfer(PID_OUT, MP, 0, 0, HS_ACK, 1);
      wr(CSR_ADDR, 8'h40);
      xfer(PID_SETUP, 8, 0, 0, HS_ACK, 1);
      rd(CSR_ADDR, 8'h11, "setup end");
      wr(CSR_ADDR, 8'hc0);
      rd(CSR_ADDR, 8'h00, "end acked");
      xfer(PID_OUT, MP + 1, 0, 0, HS_STALL, 1);
      wr(CSR_ADDR, 8'h00);
      xfer(PID_SETUP, 8, 0, 0, HS_ACK, 1);
      wr(CSR_ADDR, 8'h40);
      xfer(PID_OUT, MP, 0, 0, HS_ACK, 1);
      wr(CSR_ADDR, 8'h48);
      xfer(PID_OUT, MP, 0, 0, HS_STALL, 1);
      wr(CSR_ADDR, 8'h00);
      e = ev_n;
      xfer(PID_SETUP, 8, 0, 1, HS_NONE, 1);
      chk("events", 8'(ev_n - e), 8'h00);
      wr(CSR_ADDR, 8'h0a);
      xfer(PID_IN, 0, 0, 0, HS_ACK, 1);
      chk("in bytes", 8'(rx_n), 8'h03);
      xfer(PID_IN, 0, 0, 0, HS_STALL, 1);
      close_out();
   end
endmodule
